// ### logic/ascp_pkg.sv
// Package for the serial control port of an eight-channel 14-bit converter.
// Assumes a single core clock domain; serial pins are sampled by that clock.
package ascp_pkg;

  // ---------------------------------------------------------------------------
  // Control byte layout
  // ---------------------------------------------------------------------------
  localparam int CTRL_BITS    = 8;
  localparam int START_POS    = 7;
  localparam int CHAN_HI_POS  = 6;
  localparam int CHAN_LO_POS  = 4;
  localparam int INCFG_POS    = 3;
  localparam int POLCFG_POS   = 2;
  localparam int PWR_HI_POS   = 1;
  localparam int PWR_LO_POS   = 0;

  // ---------------------------------------------------------------------------
  // Serial clock counts
  // ---------------------------------------------------------------------------
  localparam int RESULT_BITS  = 14;
  localparam int MUX_FALL     = 5;
  localparam int HOLD_FALL    = 8;
  localparam int STROBE_LEN   = 2;
  localparam int CYCLE_CLOCKS = 18;
  // Internal-clock conversion length in core cycles
  localparam int INT_CONV_CYC = 15;

  // Power/clock mode codes
  localparam logic [1:0] PWR_FULL_DOWN = 2'h0;
  localparam logic [1:0] PWR_FAST_DOWN = 2'h1;
  localparam logic [1:0] PWR_INT_CLK   = 2'h2;
  localparam logic [1:0] PWR_EXT_CLK   = 2'h3;

  typedef struct packed {
    logic [2:0] chanSel;
    logic       inputConfig;
    logic       polarityConfig;
    logic [1:0] powerMode;
  } ascp_ctrl_type;

  typedef struct packed {
    logic csN;
    logic sclk;
    logic din;
    logic shutdownN;
  } ascp_pins_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_INTCONV,
    ST_EXTCONV,
    ST_SHIFT
  } ascp_state_type;

endpackage

// ### logic/ascp_serial_port.sv
// Serial control and data port of the converter, device side.
// Assumes pin inputs are asynchronous to core_clk; SCLK is much slower.
//
// Operation
// - Sample data input on SCLK rise, CS low
// - Change data output on SCLK fall
// - Data output released while CS high
// - Ignore SCLK activity while CS high
// - Internal mode: strobe low during conversion
// - External mode: strobe high two clocks before MSB
// - External mode: strobe released while CS high
// - External mode: SCLK paces the conversion
// - Shutdown low powers device down
// - First one after CS fall starts byte
// - Decode start, channel, config, power mode
// - Mux on fifth fall, hold on eighth
// - External conversion takes sixteen SCLK cycles after hold
`timescale 1ns/1ps
module ascp_serial_port
  import ascp_pkg::*;
#(
  parameter int RES_W = RESULT_BITS
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             clkEn,
  input  wire ascp_pins_type    pins,
  input  wire logic [RES_W-1:0] sampleValue,
  output logic                  dataOut,
  output logic                  dataOutEn,
  output logic                  convStrobe,
  output logic                  convStrobeEn,
  output ascp_ctrl_type         ctrlWord,
  output logic                  muxSwitch,
  output logic                  holdActive,
  output logic                  poweredDown
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  ascp_pins_type syncA_q;
  ascp_pins_type syncB_q;
  logic          sclkPrev_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncA_q    <= '{csN: 1'b1, sclk: 1'b0, din: 1'b0, shutdownN: 1'b1};
      syncB_q    <= '{csN: 1'b1, sclk: 1'b0, din: 1'b0, shutdownN: 1'b1};
      sclkPrev_q <= 1'b0;
    end else if (clkEn) begin
      syncA_q    <= pins;
      syncB_q    <= syncA_q;
      sclkPrev_q <= syncB_q.sclk;
    end
  end

  logic csLow;
  logic sclkRise;
  logic sclkFall;
  assign csLow    = ~syncB_q.csN;
  // Edges only count while selected
  assign sclkRise = csLow & syncB_q.sclk & ~sclkPrev_q;
  assign sclkFall = csLow & ~syncB_q.sclk & sclkPrev_q;

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  ascp_state_type state_q;
  logic [7:0]     shift_q;
  logic [4:0]     fallCnt_q;
  logic [4:0]     convCnt_q;
  logic [RES_W-1:0] result_q;
  logic           extMode_q;

  logic [7:0] byteNext;
  assign byteNext = {shift_q[6:0], syncB_q.din};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      shift_q   <= 8'h00;
      fallCnt_q <= 5'h00;
      convCnt_q <= 5'h00;
      ctrlWord  <= '0;
      extMode_q <= 1'b0;
    end else if (clkEn) begin
      if (!syncB_q.shutdownN) begin
        state_q <= ST_IDLE;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            fallCnt_q <= 5'h00;
            // Leading zeros are skipped until the start bit
            if (sclkRise && syncB_q.din) begin
              shift_q   <= 8'h01;
              fallCnt_q <= 5'h00;
              state_q   <= ST_CTRL;
            end
          end
          ST_CTRL: begin
            if (sclkRise && !shift_q[7]) begin
              shift_q <= byteNext;
            end
            if (sclkFall) begin
              fallCnt_q <= fallCnt_q + 5'h01;
              if (fallCnt_q == 5'(HOLD_FALL - 1)) begin
                ctrlWord  <= shift_q[6:0];
                extMode_q <= (shift_q[PWR_LO_POS+:2] == PWR_EXT_CLK);
                convCnt_q <= 5'h00;
                state_q   <= (shift_q[PWR_LO_POS+:2] == PWR_EXT_CLK) ? ST_EXTCONV
                                                                    : ST_INTCONV;
              end
            end
          end
          ST_INTCONV: begin
            convCnt_q <= convCnt_q + 5'h01;
            if (convCnt_q == 5'(INT_CONV_CYC - 1)) begin
              convCnt_q <= 5'h00;
              state_q   <= ST_SHIFT;
            end
          end
          ST_EXTCONV: begin
            // Strobe phase: two SCLK periods before the MSB decision
            if (sclkFall) begin
              convCnt_q <= convCnt_q + 5'h01;
              if (convCnt_q == 5'(STROBE_LEN - 1)) begin
                convCnt_q <= 5'h00;
                state_q   <= ST_SHIFT;
              end
            end
          end
          ST_SHIFT: begin
            if (sclkFall) begin
              convCnt_q <= convCnt_q + 5'h01;
              // Frame ends once every result bit has left
              if (convCnt_q == 5'(RES_W - 1)) begin
                state_q <= ST_IDLE;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
      if (syncB_q.csN && state_q != ST_INTCONV) begin
        state_q <= ST_IDLE;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Result shifter and output pins
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      result_q <= '0;
      dataOut  <= 1'b0;
    end else if (clkEn) begin
      if (state_q == ST_CTRL && sclkFall && fallCnt_q == 5'(HOLD_FALL - 1)) begin
        result_q <= sampleValue;
        dataOut  <= 1'b0;
      end else if (state_q == ST_SHIFT && sclkFall) begin
        dataOut  <= result_q[RES_W-1];
        result_q <= {result_q[RES_W-2:0], 1'b0};
      end else if (state_q != ST_SHIFT && sclkFall) begin
        dataOut  <= 1'b0;
      end
    end
  end

  assign dataOutEn = csLow;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      convStrobe <= 1'b1;
    end else if (clkEn) begin
      if (state_q == ST_CTRL && sclkFall && fallCnt_q == 5'(HOLD_FALL - 1)) begin
        // Low at hold so the external pulse starts with a rise
        convStrobe <= 1'b0;
      end else if (extMode_q) begin
        convStrobe <= (state_q == ST_EXTCONV);
      end else begin
        convStrobe <= (state_q != ST_INTCONV);
      end
    end
  end

  assign convStrobeEn = extMode_q ? csLow : 1'b1;
  assign muxSwitch    = (state_q == ST_CTRL) && (fallCnt_q >= 5'(MUX_FALL));
  assign holdActive   = (state_q == ST_INTCONV) || (state_q == ST_EXTCONV);
  assign poweredDown  = ~syncB_q.shutdownN;

endmodule

// ### sim/ascp_chk.sv
// Checker on the serial port pins, strobe and control word.
// Assumes clkEn is held high by the bench.
`timescale 1ns/1ps
module ascp_chk
  import ascp_pkg::*;
#(
  parameter int RES_W = RESULT_BITS
) (
  input logic             core_clk,
  input logic             rst,
  input logic             clkEn,
  input ascp_pins_type    pins,
  input logic [RES_W-1:0] sampleValue,
  input logic             dataOut,
  input logic             dataOutEn,
  input logic             convStrobe,
  input logic             convStrobeEn,
  input ascp_ctrl_type    ctrlWord,
  input logic             muxSwitch,
  input logic             holdActive,
  input logic             poweredDown
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire ext = ctrlWord.powerMode == PWR_EXT_CLK;
  wire intMode = ctrlWord.powerMode == PWR_INT_CLK;

  a_dout_released: assert property (pins.csN[*4] |-> !dataOutEn)
    else $error("data out driven while deselected");
  a_dout_driven: assert property ((!pins.csN)[*4] |-> dataOutEn)
    else $error("data out not driven while selected");
  a_dout_on_fall: assert property (dataOutEn && $changed(dataOut)
    |-> !pins.sclk && !$past(pins.sclk, 3)) else $error("data out moved off a fall");
  a_ctrl_frozen: assert property (!dataOutEn |=> $stable(ctrlWord))
    else $error("control word changed while deselected");
  a_ext_strobe_off: assert property ((ext && pins.csN)[*4] |-> !convStrobeEn)
    else $error("strobe driven while deselected");
  a_ext_pulse_len: assert property ($rose(convStrobe) && ext
    |-> ##[48:52] $fell(convStrobe)) else $error("strobe pulse not two clocks");
  a_int_conv_len: assert property ($fell(convStrobe) && holdActive && intMode
    |-> ##[13:17] $rose(convStrobe)) else $error("internal conversion length");
  a_power_follow: assert property ($stable(pins.shutdownN)[*4]
    |-> poweredDown == !pins.shutdownN) else $error("power state wrong");

  a_mux_window: assert property ($rose(muxSwitch) |-> ##[73:77] $fell(muxSwitch))
    else $error("mux window not three clocks");

  c_ext: cover property ($rose(convStrobe) && ext);
  c_int: cover property ($fell(convStrobe) && holdActive);
  c_pwr: cover property (poweredDown);
endmodule

// ### sim/ascp_host_model.sv
// Serial controller model: select, serial clock, data in, result capture.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ps
module ascp_host_model
  import ascp_pkg::*;
(
  input  logic          core_clk,
  input  logic          dataOut,
  input  logic          dataOutEn,
  input  logic          convStrobe,
  output ascp_pins_type pins,
  output logic [13:0]   resWord,
  output logic          resReady
);
  initial pins = 4'h9;
  initial resReady = 1'b0;
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Lead bit, then byte; capture on rises k+1 to k+14
  task automatic frame(input logic [8:0] bits, input int pre, input int nClk, input int k);
    repeat (pre) begin
      pins.din = ~pins.din; // noise while deselected
      pins.sclk = 1'b1;
      tick(12);
      pins.sclk = 1'b0;
      tick(13);
    end
    pins.csN = 1'b0;
    tick(4);
    for (int i = 1; i <= nClk; i++) begin
      if (i == 10 && k == 10) begin // wait for end of conversion
        for (int w = 0; w < 200 && !convStrobe; w++) tick(1);
      end
      pins.din = (i <= 9) ? bits[9-i] : 1'b0;
      pins.sclk = 1'b1;
      if (i > k && i <= k + 14) resWord = {resWord[12:0], dataOutEn ? dataOut : 1'bx};
      tick(12);
      pins.sclk = 1'b0; // 12 of 25 high
      tick(13);
    end
    pins.csN = 1'b1;
    pins.din = ~pins.din;
    resReady = 1'b1;
    tick(1);
    resReady = 1'b0;
    tick(20);
  endtask
endmodule

// ### sim/tb.sv
// Self-checking bench: random frames in every mode, abort, shutdown.
// Assumes the host model and checker compiled before it.
`timescale 1ns/1ps
module tb;
  import ascp_pkg::*;
  logic          core_clk, rst, resReady;
  logic          dataOut, dataOutEn, convStrobe, convStrobeEn;
  logic          muxSwitch, holdActive, poweredDown;
  logic [13:0]   sampleValue, resWord;
  logic [7:0]    lfsrQ;
  ascp_pins_type pins;
  ascp_ctrl_type ctrlWord;
  logic [21:0]   expQ[$];
  int            fail_count, checks;

  ascp_serial_port #(.RES_W(RESULT_BITS)) i_dut (.core_clk(core_clk), .rst(rst),
    .clkEn(1'b1), .pins(pins), .sampleValue(sampleValue), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .convStrobe(convStrobe), .convStrobeEn(convStrobeEn),
    .ctrlWord(ctrlWord), .muxSwitch(muxSwitch), .holdActive(holdActive),
    .poweredDown(poweredDown));
  ascp_host_model u_host (.core_clk(core_clk), .dataOut(dataOut), .dataOutEn(dataOutEn),
    .convStrobe(convStrobe), .pins(pins), .resWord(resWord), .resReady(resReady));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t frame %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic run(input logic [1:0] mode, input int pre, input int cut);
    logic [7:0] cb;
    int         k;
    lfsrQ = lfsr(lfsrQ);
    sampleValue = {lfsrQ[5:0], lfsr(lfsrQ)};
    cb = {1'b1, lfsrQ[6:2], mode};
    k = mode[0] ? 12 : 10;
    expQ.push_back({mode[1] && cut == 0, cb[6:0], mode[1] && cut == 0 ? sampleValue : 14'h0});
    u_host.frame({1'b0, cb}, pre, cut != 0 ? cut : (mode[1] ? k + 14 : 9), k);
  endtask

  always @(posedge resReady) begin
    logic [21:0] e;
    e = expQ.pop_front();
    check({e[21], ctrlWord, e[21] ? resWord : 14'h0}, e);
  end
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #150us;
    fail_count++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    sampleValue = 14'h0;
    lfsrQ = 8'h55;
    fail_count = 0;
    checks = 0;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    u_host.tick(4);
    for (int m = 0; m < 8; m++) run(m[1:0], m == 1 ? 3 : 0, 0);
    run(2'h3, 0, 14); // abort mid conversion
    run(2'h3, 0, 0);
    u_host.pins.shutdownN = 1'b0;
    u_host.tick(10);
    u_host.pins.shutdownN = 1'b1;
    u_host.tick(10);
    run(2'h2, 0, 0);
    give_verdict();
  end
endmodule

bind ascp_serial_port ascp_chk #(.RES_W(RES_W)) u_chk (.*);
